// ---- core/ustr_consts.vh ----
// Purpose: Constants for the serial port transmit/receive data path
// Assumes: 100 MHz clk, register port with one-cycle read latency
// Notes: Offsets are word indices on the plain register port
//
// Contract
// [RULE1] Buffer-empty flag high while transmit buffer empty, low while data waits.
// [RULE2] Buffer-empty interrupt requested as a level while enabled and flag set.
// [RULE3] Writing the data port clears the buffer-empty flag.
// [RULE4] Done flag sets when frame has left and no data waits.
// [RULE5] Done flag clears on interrupt service or on a written one.
// [RULE6] Done interrupt raised when done flag sets and its enable is set.
// [RULE7] Software writes zero into the buffer-empty flag position.
// [RULE8] With parity enabled, parity bit goes after data, before first stop.
// [RULE9] Transmitter disable takes effect only once shifter and buffer are empty.
// [RULE10] Receive enable claims the serial input pin for the receiver.
// [RULE11] Receiver starts on valid start bit, samples each bit at bit rate.
// [RULE12] Receiver ignores second stop bit; frame ends at first stop.
// [RULE13] On first stop bit the shifted frame moves into the receive buffer.
// [RULE14] Unused upper bits of short characters read as zero.
// [RULE15] Software reads ninth bit and status before the data port.
// [RULE16] Reading the data port advances the FIFO with its stored status.
// [RULE17] Software writes the transmit ninth bit before the low byte.
// [RULE18] Parity is xor of data bits, inverted for odd parity.
// [RULE19] Frame opens with low start bit, data least significant first.
// [RULE20] Receive-ready flag reads one while unread data exist.
// [RULE21] Enabled idle transmitter drives the output high.
`ifndef USTR_CONSTS_VH
`define USTR_CONSTS_VH
`define USTR_ADDR_W 2
`define USTR_A_DATA 2'h0
`define USTR_A_STATA 2'h1
`define USTR_A_CTRLB 2'h2
`define USTR_A_CTRLC 2'h3
// Status A bit positions
`define USTR_B_RXC 7
`define USTR_B_TXC 6
`define USTR_B_UDRE 5
`define USTR_B_FE 4
`define USTR_B_DOR 3
`define USTR_B_PE 2
// Control B bit positions
`define USTR_B_RXCIE 7
`define USTR_B_TXCIE 6
`define USTR_B_UDRIE 5
`define USTR_B_RXEN 4
`define USTR_B_TX_ENABLE_BIT 3
`define USTR_B_TX_NINTH_BIT 0
`define USTR_B_RXB8 1
// Control C fields: [2:0] size, [4] parity enable, [3] odd, [5] sync
`define USTR_B_PEN 4
`define USTR_B_PODD 3
`define USTR_B_SYNC 5
`define USTR_SZ_9 3'h7
// Sizing (one sample per bit, no oversampling): clock cycles per bit, divider width, receive FIFO depth
`define USTR_DIV_DEF 16'h0364
`define USTR_DIV_W 16
`define USTR_RXF_DEPTH 2
`endif

// ---- core/ustr_core.v ----
// Purpose: Serial port transmit and receive data path with flags
// Assumes: Inputs synchronous to clk; bit period set by parameter
// Notes: Receive FIFO holds two characters plus the shift register
`timescale 1ns/1ps
`default_nettype none
`include "ustr_consts.vh"
module ustr_core #(
  parameter [`USTR_DIV_W-1:0] BIT_CYC = `USTR_DIV_DEF
) (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Register port
  input wire [`USTR_ADDR_W-1:0] addr,
  input wire [7:0] wdata,
  input wire wr_en,
  input wire rd_en,
  output reg [7:0] rdata,
  // Interrupt service
  input wire glob_irq_en,
  input wire txc_irq_ack,
  output reg udre_irq,
  output reg txc_irq,
  output reg rxc_irq,
  // Serial pins
  input wire serial_in_pin,
  input wire sync_xfer_clock_pin,
  output reg serial_out_pin,
  output reg serial_out_oe_n,
  output reg serial_in_claim
);
  localparam TX_IDLE = 2'h0;
  localparam TX_SHIFT = 2'h1;
  localparam RX_IDLE = 2'h0;
  localparam RX_START = 2'h1;
  localparam RX_BITS = 2'h2;
  localparam [`USTR_DIV_W-1:0] HALF = BIT_CYC >> 1;

  reg [7:0] ctrl_b_r, ctrl_c_r, txbuf_r;
  reg tx_buffer_empty_flag, tx_done_flag, txbuf_b8_r;
  reg [1:0] tx_st_r, rx_st_r;
  reg [11:0] tx_sh_r;
  reg [3:0] tx_cnt_r, rx_cnt_r;
  reg [`USTR_DIV_W-1:0] tx_div_r, rx_div_r;
  reg [9:0] rx_sh_r;
  reg rx_par_r, xck_d_r, ovr_pend_r;
  // FIFO entries: {pe, dor, fe, b8, data[7:0]}
  reg [11:0] rxf_r [0:`USTR_RXF_DEPTH-1];
  reg [1:0] rxf_cnt_r;
  reg rxf_rp_r, rxf_wp_r;

  wire [2:0] csz = ctrl_c_r[2:0];
  // Sum kept four bits wide so eight data bits do not wrap to zero
  wire [3:0] nbits = (csz == `USTR_SZ_9) ? 4'h9 : (4'h5 + {2'h0, csz[1:0]});
  wire pen = ctrl_c_r[`USTR_B_PEN];
  wire podd = ctrl_c_r[`USTR_B_PODD];
  wire sync_mode = ctrl_c_r[`USTR_B_SYNC];
  wire tx_enable_bit = ctrl_b_r[`USTR_B_TX_ENABLE_BIT];
  wire rxen = ctrl_b_r[`USTR_B_RXEN];
  wire [8:0] tx_word = {txbuf_b8_r, txbuf_r};
  wire [8:0] tx_mask = (9'h1ff >> (4'h9 - nbits));
  wire tx_par = (^(tx_word & tx_mask)) ^ podd; // RULE18
  wire xck_rise = sync_xfer_clock_pin & ~xck_d_r;
  wire tx_tick = sync_mode ? xck_rise : (tx_div_r == 16'h0000);
  wire rx_tick = sync_mode ? xck_rise : (rx_div_r == 16'h0000);
  wire data_wr = wr_en & (addr == `USTR_A_DATA);
  wire data_rd = rd_en & (addr == `USTR_A_DATA);
  // Pending data still goes out after a disable while the pin is owned
  wire tx_load = (tx_st_r == TX_IDLE) & ~tx_buffer_empty_flag & (tx_enable_bit | ~serial_out_oe_n); // RULE9
  wire tx_last = (tx_st_r == TX_SHIFT) & tx_tick & (tx_cnt_r == 4'h0);
  wire rx_done = (rx_st_r == RX_BITS) & rx_tick & (rx_cnt_r == 4'h0);
  wire rx_pop = data_rd & (rxf_cnt_r != 2'h0);
  wire rx_push = rx_done & (rxf_cnt_r != 2'h2 || rx_pop);
  wire [11:0] rxf_head = rxf_r[rxf_rp_r];
  wire [3:0] rx_pbit_pos = nbits;
  wire [9:0] rx_al = rx_sh_r >> (4'ha - nbits - {3'h0, pen});
  wire [8:0] rx_data = rx_al[8:0] & tx_mask; // RULE14
  wire rx_pe_calc = pen & ((^rx_data) ^ podd ^ rx_al[rx_pbit_pos]); // RULE18
  wire rx_fe = ~serial_in_pin;
  wire [2:0] rxf_cnt3 = {1'b0, rxf_cnt_r};

  // Control registers and transmit buffer writes
  always @(posedge clk) begin
    if (!rst_n) begin
      ctrl_b_r <= 8'h00;
      ctrl_c_r <= 8'h03;
      txbuf_r <= 8'h00;
      txbuf_b8_r <= 1'b0;
    end else begin
      if (wr_en && addr == `USTR_A_CTRLB)
        ctrl_b_r <= {wdata[7:2], 1'b0, wdata[0]};
      if (wr_en && addr == `USTR_A_CTRLC)
        ctrl_c_r <= wdata;
      if (data_wr) begin
        txbuf_r <= wdata;
        txbuf_b8_r <= ctrl_b_r[`USTR_B_TX_NINTH_BIT]; // RULE17
      end
    end
  end

  // Buffer-empty and done flags; data write clear wins over empty set, done set wins over clear
  always @(posedge clk) begin
    if (!rst_n) begin
      tx_buffer_empty_flag <= 1'b1;
      tx_done_flag <= 1'b0;
    end else begin
      if (data_wr)
        tx_buffer_empty_flag <= 1'b0; // RULE3
      else if (tx_load)
        tx_buffer_empty_flag <= 1'b1; // RULE1
      if (tx_last && tx_buffer_empty_flag && !data_wr)
        tx_done_flag <= 1'b1; // RULE4
      else if (txc_irq_ack || (wr_en && addr == `USTR_A_STATA && wdata[`USTR_B_TXC]))
        tx_done_flag <= 1'b0; // RULE5
    end
  end

  // Transmit shifter: start, data LSB first, optional parity, stop bits
  always @(posedge clk) begin
    if (!rst_n) begin
      tx_st_r <= TX_IDLE;
      tx_sh_r <= 12'hfff;
      tx_cnt_r <= 4'h0;
      tx_div_r <= 16'h0000;
      serial_out_pin <= 1'b0;
    end else begin
      tx_div_r <= (tx_div_r == 16'h0000) ? BIT_CYC - 16'h0001 : tx_div_r - 16'h0001;
      case (tx_st_r)
        TX_IDLE: begin
          tx_sh_r <= 12'hfff; // RULE21
          if (tx_load) begin
            // RULE8 RULE19
            tx_sh_r <= ({3'h7, tx_word} & {3'h7, tx_mask}) | ~{3'h0, tx_mask};
            if (pen)
              tx_sh_r[nbits] <= tx_par;
            tx_sh_r <= ((({2'h3, 1'b1, tx_word & tx_mask}
              | ({12'h000} | ~{3'h7, tx_mask}))
              & ~(pen ? (12'h001 << nbits) : 12'h000))
              | ((pen && tx_par) ? (12'h001 << nbits) : 12'h000));
            tx_cnt_r <= nbits + {3'h0, pen} + {3'h0, ctrl_c_r[6]} + 4'h1;
            tx_div_r <= BIT_CYC - 16'h0001;
            tx_st_r <= TX_SHIFT;
            serial_out_pin <= 1'b0; // start bit
          end
        end
        TX_SHIFT: begin
          if (tx_tick) begin
            if (tx_cnt_r == 4'h0)
              tx_st_r <= TX_IDLE;
            else begin
              tx_cnt_r <= tx_cnt_r - 4'h1;
              serial_out_pin <= tx_sh_r[0];
              tx_sh_r <= {1'b1, tx_sh_r[11:1]};
            end
          end
        end
        default: tx_st_r <= TX_IDLE;
      endcase
      if (tx_st_r == TX_IDLE && !tx_load)
        serial_out_pin <= 1'b1; // RULE21
    end
  end

  // Pin ownership: disable waits for shifter and buffer to drain
  always @(posedge clk) begin
    if (!rst_n) begin
      serial_out_oe_n <= 1'b1;
      serial_in_claim <= 1'b0;
    end else begin
      if (tx_enable_bit)
        serial_out_oe_n <= 1'b0;
      else if (tx_st_r == TX_IDLE && tx_buffer_empty_flag)
        serial_out_oe_n <= 1'b1; // RULE9
      serial_in_claim <= rxen; // RULE10
    end
  end

  // Receiver: start detect, mid-bit sampling, stop at first stop bit
  always @(posedge clk) begin
    if (!rst_n) begin
      rx_st_r <= RX_IDLE;
      rx_sh_r <= 10'h000;
      rx_cnt_r <= 4'h0;
      rx_div_r <= 16'h0000;
      xck_d_r <= 1'b0;
      rx_par_r <= 1'b0;
    end else begin
      xck_d_r <= sync_xfer_clock_pin;
      rx_div_r <= (rx_div_r == 16'h0000) ? BIT_CYC - 16'h0001 : rx_div_r - 16'h0001;
      case (rx_st_r)
        RX_IDLE: begin
          if (rxen && !serial_in_pin) begin // RULE11
            rx_st_r <= sync_mode ? RX_BITS : RX_START;
            rx_div_r <= HALF;
            rx_cnt_r <= nbits + {3'h0, pen};
          end
        end
        RX_START: begin
          if (rx_tick)
            rx_st_r <= serial_in_pin ? RX_IDLE : RX_BITS; // false start rejected
        end
        RX_BITS: begin
          if (rx_tick) begin
            if (rx_cnt_r == 4'h0)
              rx_st_r <= RX_IDLE; // RULE12
            else begin
              rx_sh_r <= {serial_in_pin, rx_sh_r[9:1]}; // RULE11
              rx_cnt_r <= rx_cnt_r - 4'h1;
            end
          end
        end
        default: rx_st_r <= RX_IDLE;
      endcase
      if (!rxen)
        rx_st_r <= RX_IDLE;
    end
  end

  // Receive FIFO with per-entry status
  always @(posedge clk) begin
    if (!rst_n || !rxen) begin
      rxf_cnt_r <= 2'h0;
      rxf_rp_r <= 1'b0;
      rxf_wp_r <= 1'b0;
      ovr_pend_r <= 1'b0;
    end else begin
      if (rx_push) begin
        // RULE13
        rxf_r[rxf_wp_r] <= {rx_pe_calc, ovr_pend_r, rx_fe, rx_data};
        rxf_wp_r <= ~rxf_wp_r;
        ovr_pend_r <= 1'b0;
      end else if (rx_done)
        ovr_pend_r <= 1'b1; // frame lost, flag rides on next stored
      if (rx_pop)
        rxf_rp_r <= ~rxf_rp_r; // RULE16
      rxf_cnt_r <= rxf_cnt3[1:0] + {1'b0, rx_push} - {1'b0, rx_pop};
    end
  end

  // Read data, one cycle after the strobe
  always @(posedge clk) begin
    if (!rst_n) begin
      rdata <= 8'h00;
    end else if (rd_en) begin
      case (addr)
        `USTR_A_DATA: rdata <= (rxf_cnt_r != 2'h0) ? rxf_head[7:0] : 8'h00;
        `USTR_A_STATA: rdata <= {rxf_cnt_r != 2'h0, tx_done_flag, tx_buffer_empty_flag,
          rxf_head[9], rxf_head[10], rxf_head[11] & pen, 2'h0}; // RULE20
        `USTR_A_CTRLB: rdata <= {ctrl_b_r[7:2], rxf_head[8], ctrl_b_r[0]};
        `USTR_A_CTRLC: rdata <= ctrl_c_r;
        default: rdata <= 8'h00;
      endcase
    end else
      rdata <= 8'h00;
  end

  // Interrupt requests
  always @(posedge clk) begin
    if (!rst_n) begin
      udre_irq <= 1'b0;
      txc_irq <= 1'b0;
      rxc_irq <= 1'b0;
    end else begin
      udre_irq <= glob_irq_en & ctrl_b_r[`USTR_B_UDRIE] & tx_buffer_empty_flag; // RULE2
      txc_irq <= glob_irq_en & ctrl_b_r[`USTR_B_TXCIE] & tx_done_flag & ~txc_irq_ack; // RULE6
      rxc_irq <= glob_irq_en & ctrl_b_r[`USTR_B_RXCIE] & (rxf_cnt_r != 2'h0);
    end
  end
endmodule // ustr_core
`default_nettype wire

// ---- testbench/ustr_core_asserts.sv ----
// Purpose: Port checks for the serial data path
// Assumes: Sync active-low reset
// Notes: Bound to ustr_core after the module
`timescale 1ns/1ps
`default_nettype none
`include "ustr_consts.vh"
module ustr_core_asserts #(parameter [`USTR_DIV_W-1:0] BIT_CYC = `USTR_DIV_DEF) (
  // Clock, reset and register port
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [`USTR_ADDR_W-1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] rdata,
  // Interrupts and pins
  input wire logic glob_irq_en,
  input wire logic txc_irq_ack,
  input wire logic udre_irq,
  input wire logic txc_irq,
  input wire logic rxc_irq,
  input wire logic serial_out_pin,
  input wire logic serial_out_oe_n,
  input wire logic serial_in_claim
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic pin_q;
  logic [15:0] run_r;
  // Stretch length while the transmitter owns the pin, zero when untrusted
  always @(posedge clk) begin
    pin_q <= serial_out_pin;
    if (!rst_n || serial_out_oe_n) run_r <= 16'h0;
    else if (serial_out_pin != pin_q) run_r <= 16'h1;
    else if (run_r != 16'h0) run_r <= run_r + 16'h1;
  end
  a_rdata_slot_only: assert property (!$past(rd_en) |-> rdata == 8'h00)
    else $error("read data outside its slot");
  a_low_run_whole: assert property ($rose(serial_out_pin) && run_r != 16'h0 |-> run_r % BIT_CYC == 16'h0)
    else $error("low stretch not whole bits");
  a_release_line_high: assert property ($rose(serial_out_oe_n) |-> $past(serial_out_pin))
    else $error("pin released mid frame");
  a_udre_glob_gate: assert property (!$past(glob_irq_en) |-> !udre_irq)
    else $error("empty request without global enable");
  a_txc_glob_gate: assert property (!$past(glob_irq_en) |-> !txc_irq)
    else $error("done request without global enable");
  a_rxc_glob_gate: assert property (!$past(glob_irq_en) |-> !rxc_irq)
    else $error("ready request without global enable");
  a_txc_ack_clears: assert property (txc_irq_ack |-> ##[1:2] !txc_irq)
    else $error("done request stays after service");
  a_claim_on_write: assert property (wr_en && addr == `USTR_A_CTRLB && wdata[4] |-> ##[1:2] serial_in_claim)
    else $error("input not claimed");
  a_claim_off_write: assert property (wr_en && addr == `USTR_A_CTRLB && !wdata[4] |-> ##[1:2] !serial_in_claim)
    else $error("input still claimed");
  c_txc: cover property ($rose(txc_irq));
  c_rxc: cover property ($rose(rxc_irq));
  c_release: cover property ($rose(serial_out_oe_n));
endmodule // ustr_core_asserts
bind ustr_core ustr_core_asserts #(.BIT_CYC(BIT_CYC)) u_chk (.clk, .rst_n, .addr, .wdata, .wr_en,
  .rd_en, .rdata, .glob_irq_en, .txc_irq_ack, .udre_irq, .txc_irq, .rxc_irq, .serial_out_pin,
  .serial_out_oe_n, .serial_in_claim);
`default_nettype wire

// ---- testbench/ustr_core_tb.sv ----
// Purpose: Self-checking bench for the serial data path
// Assumes: 16 cycles per bit, 100 MHz clock
// Notes: Far side played by ustr_partner
`timescale 1ns/1ps
`default_nettype none
`include "ustr_consts.vh"
module ustr_core_tb;
  localparam [1:0] AD = `USTR_A_DATA, AS = `USTR_A_STATA, AB = `USTR_A_CTRLB, AC = `USTR_A_CTRLC;
  logic clk, rst_n, wr_en, rd_en, glob_irq_en, txc_irq_ack;
  logic [1:0] addr;
  logic [7:0] wdata, rdata, v;
  logic udre_irq, txc_irq, rxc_irq, serial_out_pin, serial_out_oe_n, serial_in_claim;
  wire logic serial_in_pin;
  wire logic line_tx = serial_out_oe_n ? 1'b1 : serial_out_pin;
  int n_errors = 0, checked = 0, cyc = 0, i;
  ustr_core #(.BIT_CYC(16'h0010)) dut (.clk, .rst_n, .addr, .wdata, .wr_en, .rd_en, .rdata,
    .glob_irq_en, .txc_irq_ack, .udre_irq, .txc_irq, .rxc_irq, .serial_in_pin,
    .sync_xfer_clock_pin(1'b0), .serial_out_pin, .serial_out_oe_n, .serial_in_claim);
  ustr_partner #(.BIT(16)) p (.clk, .from_dut(line_tx), .to_dut(serial_in_pin));
  task automatic report_and_stop;
    if (n_errors == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [10:0] got, input logic [10:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    d = rdata;
    @(posedge clk);
  endtask
  // Enable with the line settled, dropping any capture of the turn-on step
  task automatic tx_on(input logic [7:0] b);
    wr(AB, b);
    repeat (200) @(posedge clk);
    p.q.delete();
  endtask
  task automatic t_tx;
    rd(AS, v);
    chk(v & 8'he0, 8'h20);
    wr(AC, 8'h13);
    glob_irq_en <= 1'b1;
    tx_on(8'h68);
    chk({udre_irq, serial_out_pin, serial_out_oe_n}, 3'h6);
    wr(AD, 8'ha7);
    wr(AD, 8'h3c);
    wr(AB, 8'h60);
    rd(AS, v);
    chk({v[5], udre_irq}, 2'h0);
    for (i = 0; i < 600 && !serial_out_oe_n; i++) @(posedge clk);
    chk(p.q[0], {1'b1, ^8'ha7, 8'ha7, 1'b0});
    chk(p.q[1], {1'b1, ^8'h3c, 8'h3c, 1'b0});
    rd(AS, v);
    chk({v[6], txc_irq}, 2'h3);
    txc_irq_ack <= 1'b1;
    @(posedge clk);
    txc_irq_ack <= 1'b0;
    rd(AS, v);
    chk(v[6], 1'b0);
    glob_irq_en <= 1'b0;
    repeat (2) @(posedge clk);
    chk(udre_irq, 1'b0);
    glob_irq_en <= 1'b1;
  endtask
  task automatic t_rx;
    wr(AB, 8'h90);
    @(posedge clk);
    chk(serial_in_claim, 1'b1);
    p.send({1'b0, 8'hc3}, 8, ~^8'hc3, 1'b1);
    p.send({1'b0, 8'h5a}, 8, ^8'h5a, 1'b1);
    repeat (4) @(posedge clk);
    chk(rxc_irq, 1'b1);
    rd(AS, v);
    chk(v & 8'h9c, 8'h84);
    rd(AD, v);
    chk(v, 8'hc3);
    rd(AS, v);
    chk(v & 8'h9c, 8'h80);
    rd(AD, v);
    chk(v, 8'h5a);
    rd(AS, v);
    chk(v[7], 1'b0);
    // Two stop bits set, frames sent back to back with one stop
    wr(AC, 8'h40);
    p.send(9'h1ff, 5, -1, 1'b1);
    p.send(9'h00a, 5, -1, 1'b1);
    repeat (4) @(posedge clk);
    rd(AD, v);
    chk(v, 8'h1f);
    rd(AS, v);
    chk(v & 8'h9c, 8'h80);
    rd(AD, v);
    chk(v, 8'h0a);
  endtask
  task automatic t_nine;
    wr(AC, 8'h07);
    p.send(9'h1a5, 9, -1, 1'b1);
    repeat (4) @(posedge clk);
    rd(AB, v);
    chk(v[1], 1'b1);
    rd(AD, v);
    chk(v, 8'ha5);
    tx_on(8'h99);
    wr(AD, 8'h3c);
    for (i = 0; i < 400 && p.q.size() < 1; i++) @(posedge clk);
    repeat (20) @(posedge clk);
    chk(p.q[0], {1'b1, 9'h13c, 1'b0});
    rd(AS, v);
    chk(v[6], 1'b1);
    wr(AS, 8'h40);
    rd(AS, v);
    chk(v[6], 1'b0);
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Stop a hung run
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      report_and_stop;
    end
  end
  initial begin
    rst_n = 1'b0;
    addr = 2'h0;
    wdata = 8'h00;
    wr_en = 1'b0;
    rd_en = 1'b0;
    glob_irq_en = 1'b0;
    txc_irq_ack = 1'b0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_tx;
    t_rx;
    t_nine;
    report_and_stop;
  end
endmodule // ustr_core_tb
`default_nettype wire

// ---- testbench/ustr_partner.sv ----
// Purpose: Remote serial transceiver model
// Assumes: Line from the device already resolved with its pull-up
// Notes: Captures eleven bit slots per frame
`timescale 1ns/1ps
`default_nettype none
module ustr_partner #(parameter int BIT = 16) (
  // Line from and to the device
  input wire logic clk,
  input wire logic from_dut,
  output logic to_dut
);
  logic [10:0] q[$];
  logic [10:0] got;
  initial to_dut = 1'b1;
  // One frame: low start, data LSB first, optional parity, stop
  task automatic send(input logic [8:0] d, input int n, input int par, input logic stop);
    for (int k = 0; k <= n + 1 + (par >= 0); k++) begin
      to_dut <= (k == 0) ? 1'b0 : (k <= n) ? d[k-1] : (par >= 0 && k == n + 1) ? par[0] : stop;
      repeat (BIT) @(posedge clk);
    end
  endtask
  // Mid-bit samples after each falling edge of the device line seen while not capturing
  initial forever begin
    @(negedge from_dut);
    repeat (BIT / 2) @(posedge clk);
    for (int k = 0; k < 11; k++) begin
      if (k > 0) repeat (BIT) @(posedge clk);
      got[k] = from_dut;
    end
    q.push_back(got);
  end
endmodule // ustr_partner
`default_nettype wire
